// >>> rtl/tgd_timing_generator.sv
`timescale 1ns/1ps
module tgd_timing_generator
	import tgd_pkg::*;
#(
	parameter int WARM_STAGE = TAP_WARM
) (
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic         high_osc_input_i,
	input  wire logic         low_osc_input_i,
	input  wire logic         stop_release_i,
	input  wire tgd_ctl1_type system_control_one_i,
	input  wire tgd_ctl2_type system_control_two_i,
	input  wire logic         seventh_stage_low_clock_select_i,
	input  wire logic         wake_i,
	input  wire logic [3:0]   instr_cycles_i,
	output logic              high_osc_output_o,
	output logic              low_osc_output_o,
	output logic              high_osc_enable_o,
	output logic              low_osc_enable_o,
	output logic              main_clk_tick_o,
	output logic [1:0]        machine_state_o,
	output logic              machine_cycle_start_o,
	output logic              instr_done_o,
	output logic [DIV_W-1:0]  divider_o,
	output tgd_src_type       sources_o,
	output tgd_mode_type      mode_o
);

	localparam int UP_W = DIV_W - STAGE7_IDX;

	if (WARM_STAGE <= STAGE7_IDX || WARM_STAGE >= DIV_W) begin : g_chk
		$error("WARM_STAGE out of divider range");
	end

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic is_low_mode(input tgd_mode_type m);
		return m == MODE_LOW_CLOCK_RUN_HIGH_ON ||
			m == MODE_LOW_CLOCK_RUN_HIGH_OFF ||
			m == MODE_LOW_CLOCK_SLEEP_HIGH_ON ||
			m == MODE_LOW_CLOCK_SLEEP_HIGH_OFF;
	endfunction

	function automatic logic is_high_off(input tgd_mode_type m);
		return m == MODE_LOW_CLOCK_RUN_HIGH_OFF ||
			m == MODE_LOW_CLOCK_SLEEP_HIGH_OFF ||
			m == MODE_STOP;
	endfunction

	function automatic logic [3:0] clamp_cycles(input logic [3:0] n);
		if (n < ICYC_MIN)
			return ICYC_MIN;
		if (n > ICYC_MAX)
			return ICYC_MAX;
		return n;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] hi_sync_q, hi_sync_d;
	logic [2:0] lo_sync_q, lo_sync_d;
	logic [1:0] rel_sync_q, rel_sync_d;
	logic       hi_tick, lo_tick;

	always_comb begin
		hi_sync_d  = {hi_sync_q[1:0], high_osc_input_i};
		lo_sync_d  = {lo_sync_q[1:0], low_osc_input_i};
		rel_sync_d = {rel_sync_q[0], stop_release_i};
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_sync_q  <= 3'h0;
			lo_sync_q  <= 3'h0;
			rel_sync_q <= 2'h0;
		end else begin
			hi_sync_q  <= hi_sync_d;
			lo_sync_q  <= lo_sync_d;
			rel_sync_q <= rel_sync_d;
		end
	end

	// an oscillator that is switched off gives no ticks
	assign hi_tick = hi_sync_q[1] & ~hi_sync_q[2] & high_osc_enable_o;
	assign lo_tick = lo_sync_q[1] & ~lo_sync_q[2] & low_osc_enable_o;

	// ****************************************
	// operating mode control
	// ****************************************
	tgd_mode_type mode_q, mode_d, resume_q, resume_d;
	logic         warm_done, from_high;

	assign warm_done = divider_o[WARM_STAGE];
	assign from_high = !is_low_mode(resume_q);

	always_comb begin
		mode_d   = mode_q;
		resume_d = resume_q;
		unique case (mode_q)
		MODE_HIGH_CLOCK_RUN_SINGLE: begin
			if (system_control_one_i.stop_request) begin
				mode_d   = MODE_STOP;
				resume_d = mode_q;
			end else if (system_control_two_i.idle_request)
				mode_d = MODE_HIGH_CLOCK_IDLE;
			else if (system_control_two_i.low_osc_enable)
				mode_d = MODE_HIGH_CLOCK_RUN_DUAL;
		end
		MODE_HIGH_CLOCK_RUN_DUAL: begin
			if (system_control_one_i.stop_request) begin
				mode_d   = MODE_STOP;
				resume_d = mode_q;
			end else if (system_control_two_i.idle_request)
				mode_d = MODE_HIGH_CLOCK_IDLE;
			else if (!system_control_two_i.low_osc_enable)
				mode_d = MODE_HIGH_CLOCK_RUN_SINGLE;
			else if (system_control_two_i.system_clock_source_select)
				mode_d = MODE_LOW_CLOCK_RUN_HIGH_ON;
		end
		MODE_LOW_CLOCK_RUN_HIGH_ON: begin
			if (system_control_one_i.stop_request) begin
				mode_d   = MODE_STOP;
				resume_d = mode_q;
			end else if (system_control_two_i.idle_request)
				mode_d = MODE_LOW_CLOCK_SLEEP_HIGH_ON;
			else if (!system_control_two_i.system_clock_source_select)
				mode_d = MODE_HIGH_CLOCK_RUN_DUAL;
			else if (!system_control_two_i.high_osc_enable)
				mode_d = MODE_LOW_CLOCK_RUN_HIGH_OFF;
		end
		MODE_LOW_CLOCK_RUN_HIGH_OFF: begin
			if (system_control_one_i.stop_request) begin
				mode_d   = MODE_STOP;
				resume_d = mode_q;
			end else if (system_control_two_i.idle_request)
				mode_d = MODE_LOW_CLOCK_SLEEP_HIGH_OFF;
			else if (system_control_two_i.high_osc_enable)
				mode_d = MODE_LOW_CLOCK_RUN_HIGH_ON;
		end
		MODE_HIGH_CLOCK_IDLE: begin
			if (wake_i)
				mode_d = system_control_two_i.low_osc_enable ?
					MODE_HIGH_CLOCK_RUN_DUAL : MODE_HIGH_CLOCK_RUN_SINGLE;
		end
		MODE_LOW_CLOCK_SLEEP_HIGH_ON: begin
			if (wake_i)
				mode_d = MODE_LOW_CLOCK_RUN_HIGH_ON;
		end
		MODE_LOW_CLOCK_SLEEP_HIGH_OFF: begin
			if (wake_i)
				mode_d = MODE_LOW_CLOCK_RUN_HIGH_OFF;
		end
		MODE_STOP: begin
			// release pin is level sensitive
			if (rel_sync_q[1])
				mode_d = MODE_WARMUP;
		end
		MODE_WARMUP: begin
			if (warm_done)
				mode_d = resume_q;
		end
		default: mode_d = MODE_HIGH_CLOCK_RUN_SINGLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q   <= MODE_HIGH_CLOCK_RUN_SINGLE;
			resume_q <= MODE_HIGH_CLOCK_RUN_SINGLE;
		end else begin
			mode_q   <= mode_d;
			resume_q <= resume_d;
		end
	end

	// ****************************************
	// prescaler and divider chain
	// ****************************************
	logic [PRESC_W-1:0] presc_q, presc_d;
	logic [DIV_W-1:0]   div_d;
	logic               clr_div, high_stopped, presc_carry;
	logic               low_carry, sel_fs, stage7_in, main_tick;

	// stop entry and stop release both clear
	assign clr_div = (mode_d == MODE_STOP) != (mode_q == MODE_STOP);
	assign high_stopped = is_high_off(mode_q) ||
		(mode_q == MODE_WARMUP && !from_high);

	always_comb begin
		sel_fs = 1'b0;
		if (is_low_mode(mode_q))
			sel_fs = 1'b1;
		else if (mode_q == MODE_WARMUP)
			sel_fs = !from_high;
		else if (mode_q != MODE_HIGH_CLOCK_RUN_SINGLE)
			sel_fs = seventh_stage_low_clock_select_i;
	end

	always_comb begin
		presc_carry = hi_tick && !high_stopped && (presc_q == '1);
		low_carry   = presc_carry && (divider_o[FREEZE_W-1:0] == '1);
		stage7_in   = sel_fs ? lo_tick : low_carry;
		presc_d     = presc_q;
		div_d       = divider_o;
		if (clr_div) begin
			presc_d = '0;
			div_d   = '0;
		end else begin
			if (hi_tick && !high_stopped)
				presc_d = presc_q + PRESC_W'(1);
			div_d[FREEZE_W-1:0] = divider_o[FREEZE_W-1:0] +
				FREEZE_W'(presc_carry);
			div_d[DIV_W-1:STAGE7_IDX] = divider_o[DIV_W-1:STAGE7_IDX] +
				UP_W'(stage7_in);
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			presc_q   <= '0;
			divider_o <= '0;
		end else begin
			presc_q   <= presc_d;
			divider_o <= div_d;
		end
	end

	// ****************************************
	// main clock and machine cycle
	// ****************************************
	logic [1:0] mstate_d;
	logic [3:0] icnt_q, icnt_d;
	logic       cyc_start_d, done_d;

	always_comb begin
		main_tick = 1'b0;
		if (mode_q != MODE_STOP && mode_q != MODE_WARMUP)
			main_tick = is_low_mode(mode_q) ? lo_tick : hi_tick;
		mstate_d    = machine_state_o;
		cyc_start_d = 1'b0;
		icnt_d      = icnt_q;
		done_d      = 1'b0;
		if (main_tick) begin
			mstate_d = machine_state_o + MSTATE_STEP;
			if (machine_state_o == MSTATE_LAST) begin
				mstate_d    = MSTATE_FIRST;
				cyc_start_d = 1'b1;
				if (icnt_q + 4'h1 >= clamp_cycles(instr_cycles_i)) begin
					icnt_d = 4'h0;
					done_d = 1'b1;
				end else
					icnt_d = icnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			machine_state_o       <= MSTATE_FIRST;
			icnt_q                <= 4'h0;
			main_clk_tick_o       <= 1'b0;
			machine_cycle_start_o <= 1'b0;
			instr_done_o          <= 1'b0;
		end else begin
			machine_state_o       <= mstate_d;
			icnt_q                <= icnt_d;
			main_clk_tick_o       <= main_tick;
			machine_cycle_start_o <= cyc_start_d;
			instr_done_o          <= done_d;
		end
	end

	// ****************************************
	// oscillator control and source taps
	// ****************************************
	logic        hi_en_d, lo_en_d;
	tgd_src_type src_d;

	always_comb begin
		hi_en_d = !is_high_off(mode_d) &&
			!(mode_d == MODE_WARMUP && is_low_mode(resume_d));
		lo_en_d = mode_d != MODE_STOP &&
			(system_control_two_i.low_osc_enable || is_low_mode(mode_d));
		src_d.divider_output_pulse = divider_o[TAP_DVO];
		src_d.tbt_source           = divider_o[TAP_TBT];
		src_d.wdt_source           = divider_o[TAP_WDT];
		src_d.timer_source         = {divider_o[TAP_TMR1], divider_o[TAP_TMR0]};
		src_d.warm_source          = divider_o[WARM_STAGE];
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			high_osc_enable_o <= 1'b1;
			low_osc_enable_o  <= 1'b0;
			high_osc_output_o <= 1'b0;
			low_osc_output_o  <= 1'b0;
			sources_o         <= '0;
			mode_o            <= MODE_HIGH_CLOCK_RUN_SINGLE;
		end else begin
			high_osc_enable_o <= hi_en_d;
			low_osc_enable_o  <= lo_en_d;
			// inverting drive back to the resonator
			high_osc_output_o <= hi_en_d & ~hi_sync_q[1];
			low_osc_output_o  <= lo_en_d & ~lo_sync_q[1];
			sources_o         <= src_d;
			mode_o            <= mode_q;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	sequence s_stop_entry;
		mode_q != MODE_STOP ##1 mode_q == MODE_STOP;
	endsequence

	sequence s_stop_exit;
		mode_q == MODE_STOP ##1 mode_q == MODE_WARMUP;
	endsequence

	a_stop_clears_div: assert property (s_stop_entry |-> divider_o == '0 && presc_q == '0) else $error("divider not cleared on stop entry");
	a_release_clears_div: assert property (s_stop_exit |-> divider_o == '0) else $error("divider not cleared on release");
	a_state_wraps: assert property (main_tick && machine_state_o == MSTATE_LAST |=> machine_state_o == MSTATE_FIRST && machine_cycle_start_o) else $error("state did not wrap");
	a_state_holds: assert property (!main_tick |=> $stable(machine_state_o)) else $error("state moved without main tick");
	a_low_freeze: assert property (is_high_off(mode_q) && !clr_div |=> $stable(divider_o[FREEZE_W-1:0])) else $error("low stages moved with high clock off");
	a_low_feed: assert property (is_low_mode(mode_q) && lo_tick && !clr_div |=> divider_o[DIV_W-1:STAGE7_IDX] == $past(divider_o[DIV_W-1:STAGE7_IDX]) + UP_W'(1)) else $error("low clock not fed to stage seven");
	a_warm_feed: assert property (mode_q == MODE_WARMUP && from_high && lo_tick && !low_carry && !clr_div |=> $stable(divider_o[DIV_W-1:STAGE7_IDX])) else $error("warm-up fed from low clock");
	a_single_tick: assert property (mode_q == MODE_HIGH_CLOCK_RUN_SINGLE && hi_tick |=> main_clk_tick_o) else $error("single mode main clock not high clock");
	a_instr_bound: assert property (instr_done_o |-> $past(icnt_q) < ICYC_MAX) else $error("instruction longer than ten cycles");
	a_stop_osc_off: assert property (s_stop_entry |=> !high_osc_enable_o && !low_osc_enable_o) else $error("oscillators running in stop");

endmodule

// >>> include/tgd_pkg.sv
package tgd_pkg;

	// ****************************************
	// divider geometry
	// ****************************************
	localparam int PRESC_W    = 2;
	localparam int DIV_W      = 21;
	localparam int STAGE7_IDX = 6;
	localparam int FREEZE_W   = 6;

	// ****************************************
	// source clock taps (divider bit index)
	// ****************************************
	localparam int TAP_DVO   = 12;
	localparam int TAP_TBT   = 20;
	localparam int TAP_WDT   = 18;
	localparam int TAP_TMR0  = 7;
	localparam int TAP_TMR1  = 11;
	localparam int TAP_WARM  = 14;

	// ****************************************
	// machine cycle
	// ****************************************
	localparam int          MSTATE_W      = 2;
	localparam logic [1:0]  MSTATE_FIRST  = 2'h0;
	localparam logic [1:0]  MSTATE_LAST   = 2'h3;
	localparam logic [1:0]  MSTATE_STEP   = 2'h1;
	localparam int          ICYC_W        = 4;
	localparam logic [3:0]  ICYC_MIN      = 4'h1;
	localparam logic [3:0]  ICYC_MAX      = 4'ha;

	typedef enum logic [3:0] {
		MODE_HIGH_CLOCK_RUN_SINGLE,
		MODE_HIGH_CLOCK_RUN_DUAL,
		MODE_LOW_CLOCK_RUN_HIGH_ON,
		MODE_LOW_CLOCK_RUN_HIGH_OFF,
		MODE_HIGH_CLOCK_IDLE,
		MODE_LOW_CLOCK_SLEEP_HIGH_ON,
		MODE_LOW_CLOCK_SLEEP_HIGH_OFF,
		MODE_STOP,
		MODE_WARMUP
	} tgd_mode_type;

	typedef struct packed {
		logic stop_request;
	} tgd_ctl1_type;

	typedef struct packed {
		logic high_osc_enable;
		logic low_osc_enable;
		logic system_clock_source_select;
		logic idle_request;
	} tgd_ctl2_type;

	typedef struct packed {
		logic       divider_output_pulse;
		logic       tbt_source;
		logic       wdt_source;
		logic [1:0] timer_source;
		logic       warm_source;
	} tgd_src_type;

endpackage

// >>> verif/tgd_osc_model.sv
`timescale 1ns/1ps
// ****************************************
// resonator pair at the oscillator pins
// ****************************************
module tgd_osc_model #(
	parameter int HIGH_HALF = 3,
	parameter int LOW_HALF  = 20
) (
	input  wire logic clock_i,
	input  wire logic high_en_i,
	input  wire logic low_en_i,
	output logic      high_pin_o,
	output logic      low_pin_o
);
	int hc;
	int lc;

	initial begin
		hc = 0;
		lc = 0;
		high_pin_o = 1'b0;
		low_pin_o = 1'b0;
	end

	// a stopped resonator rests low so no stale edge appears on restart
	always @(posedge clock_i) begin
		hc <= high_en_i ? (hc + 1) % HIGH_HALF : 0;
		lc <= low_en_i ? (lc + 1) % LOW_HALF : 0;
		if (!high_en_i)
			high_pin_o <= 1'b0;
		else if (hc == HIGH_HALF - 1)
			high_pin_o <= ~high_pin_o;
		if (!low_en_i)
			low_pin_o <= 1'b0;
		else if (lc == LOW_HALF - 1)
			low_pin_o <= ~low_pin_o;
	end
endmodule

// >>> verif/timing_generator_divider_tb.sv
`timescale 1ns/1ps
module timing_generator_divider_tb
	import tgd_pkg::*;
;
	// ****************************************
	// harness
	// ****************************************
	localparam int WSTAGE = 7;
	logic             clk, rstn, hpin, lpin, srel, sel7, wake;
	logic             hout, lout, hen, len, tick, cst, done;
	logic [3:0]       icyc;
	logic [1:0]       mst;
	logic [DIV_W-1:0] div;
	tgd_ctl1_type     c1;
	tgd_ctl2_type     c2;
	tgd_src_type      src;
	tgd_mode_type     mode;
	int               fails = 0;
	int               comparisons = 0;

	tgd_timing_generator #(.WARM_STAGE(WSTAGE)) DUT (
		.clock_i(clk), .rstn_i(rstn), .high_osc_input_i(hpin),
		.low_osc_input_i(lpin), .stop_release_i(srel),
		.system_control_one_i(c1), .system_control_two_i(c2),
		.seventh_stage_low_clock_select_i(sel7), .wake_i(wake),
		.instr_cycles_i(icyc), .high_osc_output_o(hout),
		.low_osc_output_o(lout), .high_osc_enable_o(hen),
		.low_osc_enable_o(len), .main_clk_tick_o(tick),
		.machine_state_o(mst), .machine_cycle_start_o(cst),
		.instr_done_o(done), .divider_o(div), .sources_o(src),
		.mode_o(mode));

	tgd_osc_model OSC (.clock_i(clk), .high_en_i(hen), .low_en_i(len),
		.high_pin_o(hpin), .low_pin_o(lpin));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check_bits(string what, logic [31:0] exp,
			logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic check_mode(tgd_mode_type exp);
		comparisons++;
		if (mode !== exp) begin
			fails++;
			$display("CHECK FAILED mode expected %0d seen %0d", exp, mode);
		end
	endtask

	task automatic stop_test();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wait_mode(tgd_mode_type m);
		for (int i = 0; i < 40 && mode !== m; i++)
			@(posedge clk);
		check_mode(m);
	endtask

	// counts seventh-stage steps; low stages must read zero at a carry
	task automatic watch7(input int cyc, input bit warm, output int n,
			output int bad, output int mv);
		logic       p;
		logic [5:0] l;
		n = 0;
		bad = 0;
		mv = 0;
		p = div[6];
		l = div[5:0];
		for (int i = 0; i < cyc && !(warm && mode !== MODE_WARMUP); i++) begin
			@(posedge clk);
			if (div[6] !== p) begin
				n++;
				if (div[5:0] !== 6'h00)
					bad++;
			end
			if (div[5:0] !== l)
				mv++;
			p = div[6];
			l = div[5:0];
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_cycle();
		int k, tk;
		logic [1:0] s;
		k = 0;
		while (cst !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		k = 0;
		tk = 0;
		s = mst;
		do begin
			@(posedge clk);
			k++;
			if (tick === 1'b1) begin
				tk++;
				check_bits("state", 32'(2'(s + MSTATE_STEP)), 32'(mst));
				s = mst;
			end
		end while (cst !== 1'b1 && k < 300);
		check_bits("ticks per cycle", 4, tk);
		check_bits("clocks per cycle", 24, k);
		check_bits("state at start", 32'(MSTATE_FIRST), 32'(mst));
	endtask

	task automatic t_instr(logic [3:0] v, int n);
		int k, c;
		icyc <= v;
		for (int j = 0; j < 2; j++) begin
			k = 0;
			c = 0;
			do begin
				@(posedge clk);
				k++;
				if (cst === 1'b1)
					c++;
			end while (done !== 1'b1 && k < 600);
		end
		check_bits("cycles per instruction", n, c);
	endtask

	task automatic t_dual();
		int n, bad, mv;
		watch7(600, 1'b0, n, bad, mv);
		check_bits("sixth feeds seventh", 1, n <= 1 && bad == 0);
		c2.low_osc_enable <= 1'b1;
		wait_mode(MODE_HIGH_CLOCK_RUN_DUAL);
		check_bits("low osc on", 1, len);
		// select only after the low oscillator has run a while
		repeat (200) @(posedge clk);
		sel7 <= 1'b1;
		watch7(600, 1'b0, n, bad, mv);
		check_bits("low feeds seventh", 1, n >= 3);
	endtask

	task automatic t_stop();
		int n, bad, mv;
		c1.stop_request <= 1'b1;
		repeat (4) @(posedge clk);
		check_mode(MODE_STOP);
		check_bits("divider at stop", 0, div);
		check_bits("osc enables at stop", 0, {hen, len});
		check_bits("osc drives at stop", 0, {hout, lout});
		c1.stop_request <= 1'b0;
		n = 0;
		repeat (50) begin
			@(posedge clk);
			n += (tick === 1'b1);
		end
		check_bits("ticks in stop", 0, n);
		srel <= 1'b1;
		wait_mode(MODE_WARMUP);
		srel <= 1'b0;
		check_bits("divider at release", 0, div);
		watch7(8000, 1'b1, n, bad, mv);
		check_bits("warm-up carries", 1, n >= 1 && bad == 0);
		check_mode(MODE_HIGH_CLOCK_RUN_DUAL);
	endtask

	task automatic t_slow();
		int n, bad, mv;
		c2.system_clock_source_select <= 1'b1;
		wait_mode(MODE_LOW_CLOCK_RUN_HIGH_ON);
		c2.high_osc_enable <= 1'b0;
		wait_mode(MODE_LOW_CLOCK_RUN_HIGH_OFF);
		sel7 <= 1'b0;
		repeat (10) @(posedge clk);
		check_bits("high osc off", 0, hen);
		check_bits("high osc drive off", 0, hout);
		watch7(600, 1'b0, n, bad, mv);
		check_bits("low into seventh", 1, n >= 3);
		check_bits("stages one to six", 0, mv);
	endtask

	// source outputs trail the divider by one register
	task automatic t_taps();
		logic [DIV_W-1:0] p;
		tgd_src_type      e;
		for (int i = 0; i < 200; i++) begin
			p = div;
			@(posedge clk);
			e = {p[TAP_DVO], p[TAP_TBT], p[TAP_WDT], p[TAP_TMR1],
				p[TAP_TMR0], p[WSTAGE]};
			check_bits("source taps", 32'(e), 32'(src));
		end
	endtask

	// idle or sleep entry by request, return by wake
	task automatic t_idle(tgd_mode_type sm, tgd_mode_type rm, bit low);
		int n, bad, mv;
		c2.idle_request <= 1'b1;
		wait_mode(sm);
		c2.idle_request <= 1'b0;
		watch7(200, 1'b0, n, bad, mv);
		if (low)
			check_bits("sleep low feed", 1, n >= 3 && mv == 0);
		wake <= 1'b1;
		wait_mode(rm);
		wake <= 1'b0;
	endtask

	// stop entered from a low-clock mode warms up on the low clock
	task automatic t_stop_low();
		int n, bad, mv;
		c1.stop_request <= 1'b1;
		repeat (4) @(posedge clk);
		check_mode(MODE_STOP);
		check_bits("divider at low stop", 0, div);
		c1.stop_request <= 1'b0;
		srel <= 1'b1;
		wait_mode(MODE_WARMUP);
		srel <= 1'b0;
		check_bits("high osc in low warm-up", 0, hen);
		watch7(400, 1'b1, n, bad, mv);
		check_bits("low warm-up feed", 1, n >= 1 && mv == 0);
		check_mode(MODE_LOW_CLOCK_RUN_HIGH_OFF);
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		srel = 1'b0;
		sel7 = 1'b0;
		wake = 1'b0;
		icyc = 4'h1;
		c1 = '0;
		c2 = '0;
		c2.high_osc_enable = 1'b1;
		repeat (2) @(posedge clk);
		check_mode(MODE_HIGH_CLOCK_RUN_SINGLE);
		check_bits("divider at reset", 0, div);
		check_bits("osc enables at reset", 2, {hen, len});
		rstn <= 1'b1;
		t_cycle();
		t_instr(4'h0, 1);
		t_instr(4'hf, 10);
		t_instr(4'h3, 3);
		t_idle(MODE_HIGH_CLOCK_IDLE, MODE_HIGH_CLOCK_RUN_SINGLE, 1'b0);
		t_dual();
		t_stop();
		t_slow();
		t_taps();
		t_idle(MODE_LOW_CLOCK_SLEEP_HIGH_OFF, MODE_LOW_CLOCK_RUN_HIGH_OFF,
			1'b1);
		t_stop_low();
		stop_test();
	end

	// the whole run needs about six and a half thousand clocks
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		$display("CHECK FAILED run length expected done seen timeout");
		stop_test();
	end
endmodule
